// ### src/cbm_consts.svh
`ifndef CBM_CONSTS_SVH
`define CBM_CONSTS_SVH

// Register offsets in the ExCA index space.
`define CBM_OFS_MODE_C 8'h3A
`define CBM_OFS_MODE_D 8'h3B
`define CBM_OFS_CDMA 8'h3C
`define CBM_OFS_FIFO 8'h3D
`define CBM_OFS_MODE_E 8'h3E

// Offset of the ExCA image inside the CardBus register window.
`define CBM_CB_BASE 12'h800

// Number of registers in the bank.
`define CBM_NUM_REGS 5

// Reset values of the stored bits.
`define CBM_RST_MODE_C 8'h00
`define CBM_RST_MODE_D 8'h03
`define CBM_RST_CDMA 8'h18
`define CBM_RST_FIFO 8'h00
`define CBM_RST_MODE_E 8'h02

// Writable bit masks; all other bits are reserved.
`define CBM_WMASK_MODE_C 8'h0B
`define CBM_WMASK_MODE_D 8'h0F
`define CBM_WMASK_CDMA 8'h1F
`define CBM_WMASK_FIFO 8'hD0
`define CBM_WMASK_MODE_E 8'h1B

// Fixed read pattern ORed into a register on read.
`define CBM_FIXED_MODE_D 8'h40
`define CBM_FIXED_NONE 8'h00

// Field positions.
`define CBM_C_ZOOM 3
`define CBM_C_DMA_REQUEST_INPUT_HI 1
`define CBM_C_DMA_REQUEST_INPUT_LO 0
`define CBM_D_CB_CLKRUN 3
`define CBM_D_PCI_CLKRUN 2
`define CBM_D_IRQ_HI 1
`define CBM_D_IRQ_LO 0
`define CBM_CDMA_SC_IRQ 4
`define CBM_CDMA_FN_IRQ 3
`define CBM_CDMA_CH_HI 2
`define CBM_CDMA_CH_LO 0
`define CBM_FIFO_WR_FIFO 7
`define CBM_FIFO_CB_POST 6
`define CBM_FIFO_PC_POST 4
`define CBM_E_ACT_HI 4
`define CBM_E_ACT_LO 3
`define CBM_E_SPKR 1
`define CBM_E_CDMA_EN 0

`endif

// ### src/cbm_pkg.sv
package cbm_pkg;

  // System interrupt signalling modes, in field encoding order.
  typedef enum logic [1:0] {
    CBM_IRQ_PC_PCI,
    CBM_IRQ_RESERVED,
    CBM_IRQ_SERIAL,
    CBM_IRQ_PCI
  } cbm_irq_mode_e;

  // Registers of the bank, in offset order.
  typedef enum logic [2:0] {
    CBM_REG_MODE_C,
    CBM_REG_MODE_D,
    CBM_REG_CDMA,
    CBM_REG_FIFO,
    CBM_REG_MODE_E
  } cbm_reg_e;

  typedef logic [7:0] cbm_byte_t;

endpackage : cbm_pkg

// ### src/cbm_addr_decode.sv
`timescale 1ns/1ns
`include "cbm_consts.svh"

// Maps an ExCA index or a CardBus window address onto one register.
module cbm_addr_decode
  import cbm_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic accCardBus,
  input wire logic [ADDR_W-1:0] accAddr,
  output logic hit,
  output cbm_reg_e regIdx
);

  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] offset;

  // The CardBus window holds the same registers 800h higher.
  assign base = accCardBus ? ADDR_W'(`CBM_CB_BASE) : '0;
  assign offset = accAddr - base;

  // Offset match against the five documented indexes.
  always_comb begin
    hit = 1'b1;
    regIdx = CBM_REG_MODE_C;
    if (accAddr < base || offset[ADDR_W-1:8] != '0) begin
      hit = 1'b0;
    end else begin
      case (offset[7:0])
        `CBM_OFS_MODE_C: regIdx = CBM_REG_MODE_C;
        `CBM_OFS_MODE_D: regIdx = CBM_REG_MODE_D;
        `CBM_OFS_CDMA: regIdx = CBM_REG_CDMA;
        `CBM_OFS_FIFO: regIdx = CBM_REG_FIFO;
        `CBM_OFS_MODE_E: regIdx = CBM_REG_MODE_E;
        default: hit = 1'b0;
      endcase
    end
  end

endmodule : cbm_addr_decode

// ### src/cbm_mode_decode.sv
`timescale 1ns/1ns

// Turns the two routing fields into one-hot selects and picks the
// DMA request source pin.
module cbm_mode_decode (
  input wire logic [1:0] dreqRoute,
  input wire logic [1:0] actSelect,
  input wire logic inputAckPin,
  input wire logic writeProtectIo16Pin,
  input wire logic batteryVoltage2SpeakerPin,
  output logic dmaRequestInput,
  output logic dreqRouted,
  output logic ledSelected,
  output logic socketSelected
);

  // Pin selection for the DMA request; 00 leaves it idle.
  always_comb begin
    dmaRequestInput = 1'b0;
    case (dreqRoute)
      2'h1: dmaRequestInput = inputAckPin;
      2'h2: dmaRequestInput = writeProtectIo16Pin;
      2'h3: dmaRequestInput = batteryVoltage2SpeakerPin;
      default: dmaRequestInput = 1'b0;
    endcase
  end

  // Any set low bit picks the LED; 10 picks socket activity.
  assign dreqRouted = dreqRoute != 2'h0;
  assign ledSelected = actSelect[0];
  assign socketSelected = actSelect == 2'h2;

endmodule : cbm_mode_decode

// ### src/cbm_mode_regs.sv
// Operation
// - Registers at ExCA index and CardBus 800h image
// - Control C bit 3 enables zoomed video
// - Control C field 1:0 routes DMA request
// - Control D bit 3 enables CardBus clock-run
// - Control D bit 2 enables PCI clock-run
// - Control D field 1:0 picks interrupt signalling
// - DMA register bit 4 gates status-change interrupts
// - DMA register bit 3 gates functional interrupts
// - DMA register field 2:0 picks DMA channel
// - FIFO bit 7 enables CardBus write FIFO
// - FIFO bit 6 enables CardBus write posting
// - FIFO bit 4 enables PC Card posting
// - Control E field 4:3 picks activity output
// - Control E bit 1 enables speaker output
// - Control E bit 0 enables central DMA
// - Reserved bits read zero, except Control D bit 6, which reads one
`timescale 1ns/1ns
`include "cbm_consts.svh"

module cbm_mode_regs
  import cbm_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DMA_CH_W = 3
) (
  // Clock, synchronous reset and clock enable.
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Register access port shared by the index and window paths.
  input wire logic accSel,
  input wire logic accWrite,
  input wire logic accCardBus,
  input wire logic [ADDR_W-1:0] accAddr,
  input wire logic [7:0] accWrData,
  output logic accDone,
  output logic accHit,
  output logic [7:0] accRdData,
  // Card pins that can carry the DMA request.
  input wire logic inputAckPin,
  input wire logic writeProtectIo16Pin,
  input wire logic batteryVoltage2SpeakerPin,
  // Event and level inputs gated by the bank.
  input wire logic statusChangeIrqIn,
  input wire logic functionalIrqIn,
  input wire logic speakerIn,
  input wire logic socketActivityIn,
  // Decoded controls, each one clock behind its register bit.
  output logic zoomVideoEnable,
  output logic dmaRequestInput,
  output logic dmaRequestRouted,
  output logic cardBusClkRunEnable,
  output logic pciClkRunEnable,
  output cbm_irq_mode_e irqSignalMode,
  output logic irqModeReserved,
  output logic statusChangeIrqOut,
  output logic functionalIrqOut,
  output logic [DMA_CH_W-1:0] dmaChannel,
  output logic writeFifoEnable,
  output logic cardBusPostWriteEnable,
  output logic pcCardPostWriteEnable,
  output logic activityLedOutput,
  output logic socketActivityOutput,
  output logic speakerOutput,
  output logic centralDmaEnable
);

  // Refuse geometries the decode and the channel field cannot serve.
  // A wider address only adds upper bits that must decode to zero.
  if (ADDR_W < 12) begin : gAddrCheck
    $error("ADDR_W must cover the CardBus window offsets");
  end
  if (DMA_CH_W != 3) begin : gChanCheck
    $error("DMA_CH_W must match the three-bit channel field");
  end

  // Per-register constants, indexed by register number.
  // Bits outside the write mask are never stored, so reserved bits
  // read back only the fixed pattern whatever software writes.
  localparam cbm_byte_t RESETS [`CBM_NUM_REGS] = '{
    `CBM_RST_MODE_C, `CBM_RST_MODE_D, `CBM_RST_CDMA,
    `CBM_RST_FIFO, `CBM_RST_MODE_E
  };
  localparam cbm_byte_t WMASKS [`CBM_NUM_REGS] = '{
    `CBM_WMASK_MODE_C, `CBM_WMASK_MODE_D, `CBM_WMASK_CDMA,
    `CBM_WMASK_FIFO, `CBM_WMASK_MODE_E
  };
  localparam cbm_byte_t FIXED [`CBM_NUM_REGS] = '{
    `CBM_FIXED_NONE, `CBM_FIXED_MODE_D, `CBM_FIXED_NONE,
    `CBM_FIXED_NONE, `CBM_FIXED_NONE
  };

  // Storage, read views and the decode results.
  cbm_byte_t bank [`CBM_NUM_REGS];
  cbm_byte_t readView [`CBM_NUM_REGS];
  logic decHit;
  cbm_reg_e decIdx;
  logic accValid;
  cbm_byte_t next_rdData;
  // Stored images of the five registers, named for the field logic.
  cbm_byte_t modeC;
  cbm_byte_t modeD;
  cbm_byte_t cdma;
  cbm_byte_t fifoEn;
  cbm_byte_t modeE;
  logic decDreq;
  logic decDreqRouted;
  logic ledSelected;
  logic socketSelected;

  // One address decode serves both the index and the window path.
  // Both spaces land on one storage word, so the images cannot drift.
  cbm_addr_decode #(
    .ADDR_W(ADDR_W)
  ) uDecode (
    .accCardBus(accCardBus),
    .accAddr(accAddr),
    .hit(decHit),
    .regIdx(decIdx)
  );

  // An access counts only while the clock enable is high.
  assign accValid = accSel && ce;

  // Each register keeps only its writable bits and presents a read
  // view with its fixed pattern; both paths reach the same storage.
  for (genvar i = 0; i < `CBM_NUM_REGS; i++) begin : gBank
    always_ff @(posedge mclk) begin
      if (rst) begin
        bank[i] <= RESETS[i];
      end else if (accValid && accWrite && decHit &&
                   decIdx == cbm_reg_e'(i)) begin
        bank[i] <= accWrData & WMASKS[i];
      end
    end
    assign readView[i] = (bank[i] & WMASKS[i]) | FIXED[i];
  end

  assign modeC = bank[CBM_REG_MODE_C];
  assign modeD = bank[CBM_REG_MODE_D];
  assign cdma = bank[CBM_REG_CDMA];
  assign fifoEn = bank[CBM_REG_FIFO];
  assign modeE = bank[CBM_REG_MODE_E];

  // Read data for the addressed register; unmapped reads return zero.
  // Writes return zero so that stale data is never mistaken for a read.
  always_comb begin
    next_rdData = 8'h00;
    if (decHit && !accWrite) begin
      next_rdData = readView[decIdx];
    end
  end

  // Read data is held until the next access completes.
  // Holding it lets a slow host pick the byte up late.
  always_ff @(posedge mclk) begin
    if (rst) begin
      accRdData <= 8'h00;
    end else if (accValid) begin
      accRdData <= next_rdData;
    end
  end

  // Completion pulse and hit flag, one cycle after the request.
  // Both freeze with the clock enable, like every other flop.
  always_ff @(posedge mclk) begin
    if (rst) begin
      accDone <= 1'b0;
      accHit <= 1'b0;
    end else if (ce) begin
      accDone <= accSel;
      accHit <= accSel && decHit;
    end
  end

  // Route selection and activity output selection decode.
  // The decode is combinational; the flops below register its result.
  cbm_mode_decode uModes (
    .dreqRoute(modeC[`CBM_C_DMA_REQUEST_INPUT_HI:`CBM_C_DMA_REQUEST_INPUT_LO]),
    .actSelect(modeE[`CBM_E_ACT_HI:`CBM_E_ACT_LO]),
    .inputAckPin(inputAckPin),
    .writeProtectIo16Pin(writeProtectIo16Pin),
    .batteryVoltage2SpeakerPin(batteryVoltage2SpeakerPin),
    .dmaRequestInput(decDreq),
    .dreqRouted(decDreqRouted),
    .ledSelected(ledSelected),
    .socketSelected(socketSelected)
  );

  // Zoomed video tristate control.
  // The video path itself lives elsewhere; this is only its enable.
  always_ff @(posedge mclk) begin
    if (rst) begin
      zoomVideoEnable <= 1'b0;
    end else if (ce) begin
      zoomVideoEnable <= modeC[`CBM_C_ZOOM];
    end
  end

  // DMA request taken from the selected card pin.
  // A disabled route forces the request low rather than floating.
  always_ff @(posedge mclk) begin
    if (rst) begin
      dmaRequestInput <= 1'b0;
      dmaRequestRouted <= 1'b0;
    end else if (ce) begin
      dmaRequestInput <= decDreq;
      dmaRequestRouted <= decDreqRouted;
    end
  end

  // Clock-run protocol enables for both buses.
  // Both come out of reset disabled so the clocks keep running.
  always_ff @(posedge mclk) begin
    if (rst) begin
      cardBusClkRunEnable <= 1'b0;
      pciClkRunEnable <= 1'b0;
    end else if (ce) begin
      cardBusClkRunEnable <= modeD[`CBM_D_CB_CLKRUN];
      pciClkRunEnable <= modeD[`CBM_D_PCI_CLKRUN];
    end
  end

  // System interrupt signalling mode; code 01 is flagged reserved.
  // The reserved code is kept as written so software reads it back,
  // and the flag lets the interrupt logic treat it as unsupported.
  always_ff @(posedge mclk) begin
    if (rst) begin
      irqSignalMode <= CBM_IRQ_PCI;
      irqModeReserved <= 1'b0;
    end else if (ce) begin
      irqSignalMode <= cbm_irq_mode_e'(
        modeD[`CBM_D_IRQ_HI:`CBM_D_IRQ_LO]);
      irqModeReserved <= modeD[`CBM_D_IRQ_HI:`CBM_D_IRQ_LO] ==
                         2'h1;
    end
  end

  // Interrupt gating; a cleared enable suppresses the event outright.
  // Gating is on the level, so an event pending when the enable is
  // cleared drops out at the next edge.
  always_ff @(posedge mclk) begin
    if (rst) begin
      statusChangeIrqOut <= 1'b0;
      functionalIrqOut <= 1'b0;
    end else if (ce) begin
      statusChangeIrqOut <= statusChangeIrqIn &&
                            cdma[`CBM_CDMA_SC_IRQ];
      functionalIrqOut <= functionalIrqIn &&
                          cdma[`CBM_CDMA_FN_IRQ];
    end
  end

  // Centralized DMA channel and function enable.
  // The channel number is passed out whether or not the function is enabled.
  always_ff @(posedge mclk) begin
    if (rst) begin
      dmaChannel <= '0;
      centralDmaEnable <= 1'b0;
    end else if (ce) begin
      dmaChannel <= cdma[`CBM_CDMA_CH_HI:`CBM_CDMA_CH_LO];
      centralDmaEnable <= modeE[`CBM_E_CDMA_EN];
    end
  end

  // Write FIFO and posting enables.
  // All three come out of reset disabled.
  always_ff @(posedge mclk) begin
    if (rst) begin
      writeFifoEnable <= 1'b0;
      cardBusPostWriteEnable <= 1'b0;
      pcCardPostWriteEnable <= 1'b0;
    end else if (ce) begin
      writeFifoEnable <= fifoEn[`CBM_FIFO_WR_FIFO];
      cardBusPostWriteEnable <= fifoEn[`CBM_FIFO_CB_POST];
      pcCardPostWriteEnable <= fifoEn[`CBM_FIFO_PC_POST];
    end
  end

  // Socket activity drives whichever activity output is selected.
  // Code 11 counts as the LED choice, since its low bit is set.
  always_ff @(posedge mclk) begin
    if (rst) begin
      activityLedOutput <= 1'b0;
      socketActivityOutput <= 1'b0;
    end else if (ce) begin
      activityLedOutput <= socketActivityIn && ledSelected;
      socketActivityOutput <= socketActivityIn &&
                              socketSelected;
    end
  end

  // Speaker passthrough, silenced when the function is disabled.
  // The enable comes out of reset set, so the speaker passes by default.
  always_ff @(posedge mclk) begin
    if (rst) begin
      speakerOutput <= 1'b0;
    end else if (ce) begin
      speakerOutput <= speakerIn && modeE[`CBM_E_SPKR];
    end
  end

endmodule : cbm_mode_regs

// ### test/cbm_mode_regs_sva.sv
`timescale 1ns/1ns
`include "cbm_consts.svh"

// Ties access answers and field outputs of the bank to their causes.
module cbm_mode_regs_sva
  import cbm_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DMA_CH_W = 3
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic accSel,
  input wire logic accWrite,
  input wire logic accCardBus,
  input wire logic [ADDR_W-1:0] accAddr,
  input wire logic [7:0] accWrData,
  input wire logic accDone,
  input wire logic accHit,
  input wire logic [7:0] accRdData,
  input wire logic speakerIn,
  input wire logic zoomVideoEnable,
  input wire logic cardBusClkRunEnable,
  input wire logic pciClkRunEnable,
  input wire cbm_irq_mode_e irqSignalMode,
  input wire logic [DMA_CH_W-1:0] dmaChannel,
  input wire logic writeFifoEnable,
  input wire logic cardBusPostWriteEnable,
  input wire logic pcCardPostWriteEnable,
  input wire logic activityLedOutput,
  input wire logic socketActivityOutput,
  input wire logic speakerOutput,
  input wire logic centralDmaEnable
);
  logic selOk;
  logic wrSel;
  logic [7:0] ofs;

  // A taken access whose upper address bits match its space.
  assign selOk = ce && accSel && accAddr[11:8] == (accCardBus ? 4'h8 : 4'h0);
  assign wrSel = selOk && accWrite;
  assign ofs = accAddr[7:0];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_image_hit: assert property (
    selOk && ofs inside {[8'h3A:8'h3E]} |=> accDone && accHit)
    else $error("mapped access not answered as a hit");
  a_zoom_write: assert property (
    wrSel && ofs == `CBM_OFS_MODE_C ##1 ce
    |=> zoomVideoEnable == $past(accWrData[3], 2))
    else $error("zoom enable differs from written bit");
  a_mode_d_write: assert property (
    wrSel && ofs == `CBM_OFS_MODE_D ##1 ce
    |=> cardBusClkRunEnable == $past(accWrData[3], 2)
    && pciClkRunEnable == $past(accWrData[2], 2)
    && irqSignalMode == $past(accWrData[1:0], 2))
    else $error("clock-run or interrupt mode differs from write");
  a_channel_write: assert property (
    wrSel && ofs == `CBM_OFS_CDMA ##1 ce
    |=> dmaChannel == $past(accWrData[2:0], 2))
    else $error("channel differs from written field");
  a_fifo_write: assert property (
    wrSel && ofs == `CBM_OFS_FIFO ##1 ce
    |=> {writeFifoEnable, cardBusPostWriteEnable, pcCardPostWriteEnable}
    == {$past(accWrData[7], 2), $past(accWrData[6], 2),
    $past(accWrData[4], 2)})
    else $error("write enables differ from written bits");
  a_cdma_write: assert property (
    wrSel && ofs == `CBM_OFS_MODE_E ##1 ce
    |=> centralDmaEnable == $past(accWrData[0], 2))
    else $error("central DMA enable differs from written bit");
  a_d_fixed_read: assert property (
    selOk && !accWrite && ofs == `CBM_OFS_MODE_D
    |=> accRdData[7:4] == 4'h4)
    else $error("upper nibble of mode D not fixed");
  a_rsvd_read: assert property (
    selOk && !accWrite && ofs == `CBM_OFS_MODE_E
    |=> accRdData[7:5] == 3'h0 && !accRdData[2])
    else $error("reserved bits of mode E not zero");
  a_speaker_gate: assert property (
    $past(ce) && !$past(speakerIn) |-> !speakerOutput)
    else $error("speaker output without speaker input");
  a_act_single: assert property (
    !(activityLedOutput && socketActivityOutput))
    else $error("both activity outputs selected");

  c_read_hit: cover property (selOk && !accWrite ##1 accHit);
  c_led: cover property (activityLedOutput);
  c_socket: cover property (socketActivityOutput);
endmodule : cbm_mode_regs_sva

bind cbm_mode_regs cbm_mode_regs_sva #(.ADDR_W(ADDR_W), .DMA_CH_W(DMA_CH_W))
  u_sva (.*);

// ### test/tb.sv
`timescale 1ns/1ns

module tb;
  import cbm_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, accSel = 1'b0;
  logic accWrite = 1'b0, accCardBus = 1'b0;
  logic [11:0] accAddr = 12'h000;
  logic [7:0] accWrData = 8'h00;
  logic inputAckPin = 1'b0, writeProtectIo16Pin = 1'b0;
  logic batteryVoltage2SpeakerPin = 1'b0, statusChangeIrqIn = 1'b1;
  logic functionalIrqIn = 1'b1, speakerIn = 1'b1, socketActivityIn = 1'b1;
  logic accDone, accHit, zoomVideoEnable, dmaRequestInput, dmaRequestRouted;
  logic cardBusClkRunEnable, pciClkRunEnable, irqModeReserved;
  logic statusChangeIrqOut, functionalIrqOut, writeFifoEnable;
  logic cardBusPostWriteEnable, pcCardPostWriteEnable, activityLedOutput;
  logic socketActivityOutput, speakerOutput, centralDmaEnable;
  logic [7:0] accRdData, rd;
  logic [2:0] dmaChannel;
  cbm_irq_mode_e irqSignalMode;
  int nErrors = 0, comparisons = 0, cycles = 0;

  cbm_mode_regs DUT (.*);

  // Clock and hang guard.
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      nErrors++;
      endOfTest();
    end
  end

  // Compares one value and reports a mismatch.
  task automatic chk(input logic [7:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      nErrors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what,
        got, exp);
    end
  endtask : chk

  // Presents one access and takes its answer one cycle later.
  task automatic acc(input logic w, c, input logic [11:0] a,
    input logic [7:0] d);
    @(posedge mclk);
    #1;
    accSel = 1'b1;
    accWrite = w;
    accCardBus = c;
    accAddr = a;
    accWrData = d;
    @(posedge mclk);
    #1;
    accSel = 1'b0;
    rd = accRdData;
    chk(accDone, 8'h01, "done");
  endtask : acc

  // Writes a register, then waits for the derived outputs.
  task automatic wr(input logic c, input logic [7:0] o, d);
    acc(1'b1, c, {c ? 4'h8 : 4'h0, o}, d);
    @(posedge mclk);
    #1;
  endtask : wr

  task automatic tReset();
    logic [7:0] ex [5] = '{8'h00, 8'h43, 8'h18, 8'h00, 8'h02};
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, 1'b0, 12'h03A + 12'(i), 8'h00);
      chk(rd, ex[i], "reset");
    end
    chk(irqSignalMode, CBM_IRQ_PCI, "irq mode");
    chk({statusChangeIrqOut, functionalIrqOut, speakerOutput}, 8'h07,
      "gates");
  endtask : tReset

  // Both windows hold one image; reserved bits stay clear except mode D bit 6.
  task automatic tMirror();
    logic [7:0] hi [5] = '{8'h0B, 8'h4F, 8'h1F, 8'hD0, 8'h1B};
    for (int i = 0; i < 5; i++) begin
      wr(1'b0, 8'h3A + 8'(i), 8'hFF);
      acc(1'b0, 1'b1, 12'h83A + 12'(i), 8'h00);
      chk(rd, hi[i], "image high");
      chk(accHit, 8'h01, "hit");
      wr(1'b1, 8'h3A + 8'(i), 8'h00);
      acc(1'b0, 1'b0, 12'h03A + 12'(i), 8'h00);
      chk(rd, i == 1 ? 8'h40 : 8'h00, "image low");
    end
  endtask : tMirror

  task automatic tRoute();
    logic [2:0] p [2] = '{3'b101, 3'b010};
    for (int k = 0; k < 8; k++) begin
      {batteryVoltage2SpeakerPin, writeProtectIo16Pin, inputAckPin} = p[k/4];
      wr(1'b0, 8'h3A, {4'h0, k[0], 1'b0, k[1:0]});
      chk(zoomVideoEnable, k[0], "zoom");
      chk(dmaRequestRouted, k[1:0] != 0, "routed");
      chk(dmaRequestInput, k[1:0] == 0 ? 1'b0 : p[k/4][k[1:0]-1],
        "dma_request_input");
    end
  endtask : tRoute

  task automatic tModeD();
    for (int m = 0; m < 4; m++) begin
      wr(1'b1, 8'h3B, {4'h0, m[0], m[1], m[1:0]});
      chk(irqSignalMode, m[1:0], "mode");
      chk(irqModeReserved, m == 1, "rsvd mode");
      chk({cardBusClkRunEnable, pciClkRunEnable}, {m[0], m[1]},
        "clkrun");
    end
  endtask : tModeD

  task automatic tDma();
    for (int c = 0; c < 8; c++) begin
      wr(1'b0, 8'h3C, {3'h0, c[0], c[1], c[2:0]});
      chk(dmaChannel, c[2:0], "channel");
      chk({statusChangeIrqOut, functionalIrqOut}, {c[0], c[1]},
        "irq gates");
    end
  endtask : tDma

  task automatic tFifo();
    logic [7:0] v [3] = '{8'h80, 8'h40, 8'h10};
    for (int i = 0; i < 3; i++) begin
      wr(1'b1, 8'h3D, v[i]);
      chk({writeFifoEnable, cardBusPostWriteEnable, pcCardPostWriteEnable},
        {v[i][7], v[i][6], v[i][4]}, "fifo");
    end
  endtask : tFifo

  task automatic tModeE();
    for (int i = 0; i < 4; i++) begin
      wr(1'b0, 8'h3E, {3'h0, i[1:0], 1'b0, i[0], i[1]});
      chk({activityLedOutput, socketActivityOutput}, {i[0], i == 2},
        "activity");
      chk({speakerOutput, centralDmaEnable}, {i[0], i[1]},
        "spkr dma");
    end
    {statusChangeIrqIn, functionalIrqIn, speakerIn, socketActivityIn} = 4'h0;
    @(posedge mclk);
    #1;
    chk({statusChangeIrqOut, functionalIrqOut}, 8'h00,
      "irq low");
    chk({speakerOutput, activityLedOutput}, 8'h00,
      "spkr low");
  endtask : tModeE

  // Unmapped places and a frozen clock enable leave the bank alone.
  task automatic tRefused();
    logic [11:0] a [3] = '{12'h83A, 12'h03A, 12'h83F};
    wr(1'b0, 8'h3A, 8'h00);
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, i > 0, a[i], 8'hFF);
      acc(1'b0, i > 0, a[i], 8'h00);
      chk(accHit, 8'h00, "unmapped hit");
      chk(rd, 8'h00, "unmapped");
    end
    @(posedge mclk);
    #1;
    {ce, accSel, accWrite, accCardBus} = 4'b0110;
    accAddr = 12'h03A;
    accWrData = 8'hFF;
    @(posedge mclk);
    #1;
    {ce, accSel} = 2'b10;
    chk(accDone, 8'h00, "frozen");
    acc(1'b0, 1'b0, 12'h03A, 8'h00);
    chk(rd, 8'h00, "mode C kept");
  endtask : tRefused

  // Closing report.
  task automatic endOfTest();
    $display("errors %0d comparisons %0d", nErrors, comparisons);
    if (nErrors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : endOfTest

  // Main sequence.
  initial begin
    repeat (6) @(posedge mclk);
    #1;
    rst = 1'b0;
    tReset();
    tMirror();
    tRoute();
    tModeD();
    tDma();
    tFifo();
    tModeE();
    tRefused();
    endOfTest();
  end
endmodule : tb
